/* File: common/omcg_pkg.sv */
// package for the operating-mode and clock-gating controller
// assumes one 100 MHz bus clock; oscillator activity arrives as sampled tick levels
package omcg_pkg;

  localparam logic [7:0] OMCG_SMC_OFS    = 8'h00;
  localparam logic [7:0] OMCG_CFG_OFS    = 8'h04;
  localparam logic [7:0] OMCG_STAT_OFS   = 8'h08;

  localparam int OMCG_DIV_LSB  = 5;
  localparam int OMCG_FWE_BIT  = 4;
  localparam int OMCG_LRDY_BIT = 3;
  localparam int OMCG_HRDY_BIT = 2;
  localparam int OMCG_IOH_BIT  = 1;
  localparam int OMCG_HCS_BIT  = 0;

  localparam logic [2:0] OMCG_DIV_RST = 3'h0;
  localparam logic       OMCG_FWE_RST = 1'b0;
  localparam logic       OMCG_IOH_RST = 1'b1;
  localparam logic       OMCG_HCS_RST = 1'b1;
  localparam logic [5:0] OMCG_CFG_RST = 6'h00;

  localparam logic [10:0] OMCG_XTAL_CYC  = 11'd1024;
  localparam logic [10:0] OMCG_HRC_CYC   = 11'd16;
  localparam logic [10:0] OMCG_LRC_CYC   = 11'd2;

  typedef enum logic [2:0] {
    OMCG_NORMAL, OMCG_SLOW, OMCG_DEEP_SLEEP,
    OMCG_SLEEP_KEEP_SUB, OMCG_IDLE_SYSCLK_OFF, OMCG_IDLE_SYSCLK_ON
  } omcg_mode_e;

  typedef struct packed {
    logic cpu_run;
    logic sysclk_on;
    logic sysclk_low;
    logic high_osc_on;
    logic low_osc_on;
    logic sub_on;
    logic wdt_on;
    logic tbc_on;
  } omcg_gates_s;

  typedef struct packed {
    logic idle_sysclk_keep;
    logic lvd_en;
    logic wdt_en;
    logic wdt_src_sub;
    logic high_src_crystal;
    logic low_src_crystal;
  } omcg_cfg_s;

endpackage

/* File: rtl/omcg_ctrl.sv */
// operating-mode controller: APB registers, mode machine, clock gates, ready flags
// assumes halt/wake pulses come from pclk logic; oscillator ticks are asynchronous
`timescale 1ns/1ps
`default_nettype none
module omcg_ctrl (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               halt_req,
  input  wire logic               wake_req,
  input  wire logic               high_osc_tick,
  input  wire logic               low_osc_tick,
  output omcg_pkg::omcg_gates_s   gates,
  output logic                    sysclk_tick
);
  import omcg_pkg::*;

  typedef struct packed {
    omcg_mode_e  mode;
    logic [2:0]  div_sel;
    logic        fast_wakeup_enable;
    logic        idle_on_halt;
    logic        high_clock_select;
    omcg_cfg_s   cfg;
    logic        high_osc_ready;
    logic        low_osc_ready;
    logic [10:0] hcnt;
    logic [10:0] lcnt;
    logic [5:0]  divcnt;
    logic [1:0]  hsync;
    logic        hprev;
    logic [1:0]  lsync;
    logic        lprev;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    omcg_gates_s gates;
    logic        tick;
  } omcg_state_s;

  omcg_state_s st;
  omcg_state_s next_st;

  // terminal count of the divider, zero for the undivided or low-speed clock
  function automatic logic [5:0] div_limit(input logic hsel, input logic [2:0] sel);
    logic [5:0] r;
    r = 6'h00;
    if (!hsel)
    begin
      case (sel)
        3'h2:    r = 6'h3F;
        3'h3:    r = 6'h1F;
        3'h4:    r = 6'h0F;
        3'h5:    r = 6'h07;
        3'h6:    r = 6'h03;
        3'h7:    r = 6'h01;
        default: r = 6'h00;
      endcase
    end
    return r;
  endfunction

  function automatic logic sel_is_low(input logic hsel, input logic [2:0] sel);
    return !hsel && (sel[2:1] == 2'h0);
  endfunction

  logic        setup;
  logic        wr_now;
  logic        hit;
  logic        hedge;
  logic        ledge;
  logic        run_low;
  logic        keep_sub;
  logic [10:0] hlim;
  logic [10:0] llim;
  logic [31:0] rd_smc;
  logic [31:0] rd_cfg;
  logic [31:0] rd_stat;

  always_comb
  begin
    next_st = st;
    setup   = psel && !penable;
    wr_now  = psel && penable && st.pready && pwrite;
    hit     = (paddr == OMCG_SMC_OFS) || (paddr == OMCG_CFG_OFS) || (paddr == OMCG_STAT_OFS);
    hedge   = st.hsync[1] && !st.hprev;
    ledge   = st.lsync[1] && !st.lprev;
    run_low = sel_is_low(st.high_clock_select, st.div_sel);
    keep_sub = st.cfg.lvd_en || (st.cfg.wdt_en && st.cfg.wdt_src_sub);
    hlim    = st.cfg.high_src_crystal ? OMCG_XTAL_CYC : OMCG_HRC_CYC;
    llim    = st.cfg.low_src_crystal ? OMCG_XTAL_CYC : OMCG_LRC_CYC;

    rd_smc = {24'h0, st.div_sel, st.fast_wakeup_enable, st.low_osc_ready,
              st.high_osc_ready, st.idle_on_halt, st.high_clock_select};
    rd_cfg  = {26'h0, st.cfg};
    rd_stat = {16'h0, st.gates,
               2'h0,
               st.mode == OMCG_IDLE_SYSCLK_ON, st.mode == OMCG_IDLE_SYSCLK_OFF,
               st.mode == OMCG_SLEEP_KEEP_SUB, st.mode == OMCG_DEEP_SLEEP,
               st.mode == OMCG_SLOW, st.mode == OMCG_NORMAL};

    // bus: zero-wait access, answer prepared in the setup cycle
    next_st.pready  = setup;
    next_st.pslverr = setup && !hit;
    if (setup)
    begin
      next_st.prdata = 32'h0;
      if (!pwrite)
      begin
        case (paddr)
          OMCG_SMC_OFS:  next_st.prdata = rd_smc;
          OMCG_CFG_OFS:  next_st.prdata = rd_cfg;
          OMCG_STAT_OFS: next_st.prdata = rd_stat;
          default:       next_st.prdata = 32'h0;
        endcase
      end
    end
    if (wr_now && paddr == OMCG_SMC_OFS)
    begin
      // ready flags are hardware status, so bits 3 and 2 are dropped
      next_st.div_sel            = pwdata[OMCG_DIV_LSB +: 3];
      next_st.fast_wakeup_enable = pwdata[OMCG_FWE_BIT];
      next_st.idle_on_halt       = pwdata[OMCG_IOH_BIT];
      next_st.high_clock_select  = pwdata[OMCG_HCS_BIT];
    end
    if (wr_now && paddr == OMCG_CFG_OFS)
      next_st.cfg = pwdata[5:0];

    // oscillator activity synchronisers
    next_st.hsync = {st.hsync[0], high_osc_tick};
    next_st.hprev = st.hsync[1];
    next_st.lsync = {st.lsync[0], low_osc_tick};
    next_st.lprev = st.lsync[1];

    // mode machine
    case (st.mode)
      OMCG_NORMAL, OMCG_SLOW:
      begin
        next_st.mode = run_low ? OMCG_SLOW : OMCG_NORMAL;
        if (halt_req)
        begin
          if (!st.idle_on_halt)
            next_st.mode = (!keep_sub) ? OMCG_DEEP_SLEEP : OMCG_SLEEP_KEEP_SUB;
          else if (st.cfg.idle_sysclk_keep)
            next_st.mode = OMCG_IDLE_SYSCLK_ON;
          else
            next_st.mode = OMCG_IDLE_SYSCLK_OFF;
        end
      end
      OMCG_DEEP_SLEEP, OMCG_SLEEP_KEEP_SUB, OMCG_IDLE_SYSCLK_OFF, OMCG_IDLE_SYSCLK_ON:
      begin
        if (wake_req)
          next_st.mode = run_low ? OMCG_SLOW : OMCG_NORMAL;
      end
      default: next_st.mode = OMCG_NORMAL;
    endcase

    // gates follow the mode being entered so they line up with it
    next_st.gates = '0;
    next_st.gates.sysclk_low = run_low;
    case (next_st.mode)
      OMCG_NORMAL, OMCG_SLOW:
      begin
        next_st.gates.cpu_run     = 1'b1;
        next_st.gates.sysclk_on   = 1'b1;
        next_st.gates.high_osc_on = !run_low;
        next_st.gates.low_osc_on  = 1'b1;
        next_st.gates.sub_on      = 1'b1;
        next_st.gates.wdt_on      = 1'b1;
        next_st.gates.tbc_on      = 1'b1;
      end
      OMCG_DEEP_SLEEP:
        next_st.gates = '0;
      OMCG_SLEEP_KEEP_SUB:
      begin
        next_st.gates.low_osc_on = 1'b1;
        next_st.gates.sub_on     = keep_sub;
        next_st.gates.wdt_on     = keep_sub;
      end
      OMCG_IDLE_SYSCLK_OFF:
      begin
        next_st.gates.low_osc_on = 1'b1;
        next_st.gates.sub_on     = 1'b1;
        next_st.gates.tbc_on     = 1'b1;
        next_st.gates.wdt_on     = st.cfg.wdt_src_sub;
      end
      OMCG_IDLE_SYSCLK_ON:
      begin
        next_st.gates.sysclk_on   = 1'b1;
        next_st.gates.high_osc_on = !run_low;
        next_st.gates.low_osc_on  = 1'b1;
        next_st.gates.sub_on      = 1'b1;
        next_st.gates.wdt_on      = 1'b1;
        next_st.gates.tbc_on      = 1'b1;
      end
      default: next_st.gates = '0;
    endcase

    // ready flags restart their count whenever the oscillator is stopped
    if (!st.gates.high_osc_on)
    begin
      next_st.high_osc_ready = 1'b0;
      next_st.hcnt = 11'h0;
    end
    else if (!st.high_osc_ready && hedge)
    begin
      next_st.hcnt = st.hcnt + 11'h1;
      if (st.hcnt == hlim - 11'h1)
        next_st.high_osc_ready = 1'b1;
    end
    if (!st.gates.low_osc_on)
    begin
      next_st.low_osc_ready = 1'b0;
      next_st.lcnt = 11'h0;
    end
    else if (!st.low_osc_ready && ledge)
    begin
      next_st.lcnt = st.lcnt + 11'h1;
      if (st.lcnt == llim - 11'h1)
        next_st.low_osc_ready = 1'b1;
    end

    // system clock enable pulse: one per selected source edge, divided when asked
    next_st.tick = 1'b0;
    if (st.gates.sysclk_on)
    begin
      if (run_low)
        next_st.tick = ledge;
      else if (hedge)
      begin
        if (st.divcnt >= div_limit(st.high_clock_select, st.div_sel))
        begin
          next_st.divcnt = 6'h0;
          next_st.tick   = 1'b1;
        end
        else
          next_st.divcnt = st.divcnt + 6'h1;
      end
    end
    else
      next_st.divcnt = 6'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st                    <= '0;
      // synchronisers start high so an oscillator already high at release gives no false edge
      st.hsync              <= 2'h3;
      st.hprev              <= 1'b1;
      st.lsync              <= 2'h3;
      st.lprev              <= 1'b1;
      st.mode               <= OMCG_NORMAL;
      st.div_sel            <= OMCG_DIV_RST;
      st.fast_wakeup_enable <= OMCG_FWE_RST;
      st.idle_on_halt       <= OMCG_IOH_RST;
      st.high_clock_select  <= OMCG_HCS_RST;
      st.cfg                <= OMCG_CFG_RST;
      st.gates              <= 8'hDF;
    end
    else
      st <= next_st;
  end

  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign gates       = st.gates;
  assign sysclk_tick = st.tick;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_normal_all_on;
    st.mode == OMCG_NORMAL |-> st.gates.sub_on && st.gates.wdt_on && st.gates.tbc_on;
  endproperty
  a_normal_all_on: assert property (p_normal_all_on) else $error("normal clocks off");

  property p_slow_high_off;
    st.mode == OMCG_SLOW |-> !st.gates.high_osc_on && st.gates.cpu_run;
  endproperty
  a_slow_high_off: assert property (p_slow_high_off) else $error("slow with high osc");

  property p_halt_sleep;
    (st.mode == OMCG_NORMAL || st.mode == OMCG_SLOW) && halt_req && !st.idle_on_halt
      |=> (st.mode == OMCG_DEEP_SLEEP || st.mode == OMCG_SLEEP_KEEP_SUB) && !st.gates.cpu_run;
  endproperty
  a_halt_sleep: assert property (p_halt_sleep) else $error("halt missed sleep");

  property p_deep_off;
    st.mode == OMCG_DEEP_SLEEP |-> st.gates == '0;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("deep sleep clock on");

  property p_lvd_blocks_deep;
    (st.mode == OMCG_NORMAL || st.mode == OMCG_SLOW) && halt_req && !st.idle_on_halt
      && st.cfg.lvd_en |=> st.mode == OMCG_SLEEP_KEEP_SUB;
  endproperty
  a_lvd_blocks_deep: assert property (p_lvd_blocks_deep) else $error("deep sleep with lvd on");

  property p_sleep_sub;
    st.mode == OMCG_SLEEP_KEEP_SUB && $stable(st.cfg)
      |-> st.gates.sub_on == keep_sub && !st.gates.tbc_on && !st.gates.sysclk_on;
  endproperty
  a_sleep_sub: assert property (p_sleep_sub) else $error("sleep_keep_sub gates wrong");

  property p_idle_pick;
    (st.mode == OMCG_NORMAL || st.mode == OMCG_SLOW) && halt_req && st.idle_on_halt
      |=> st.mode == ($past(st.cfg.idle_sysclk_keep) ? OMCG_IDLE_SYSCLK_ON : OMCG_IDLE_SYSCLK_OFF);
  endproperty
  a_idle_pick: assert property (p_idle_pick) else $error("wrong idle mode");

  property p_idle_off;
    st.mode == OMCG_IDLE_SYSCLK_OFF && $stable(st.cfg)
      |-> st.gates.sub_on && st.gates.tbc_on && !st.gates.high_osc_on
          && st.gates.wdt_on == st.cfg.wdt_src_sub;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle_sysclk_off gates wrong");

  property p_idle_on;
    st.mode == OMCG_IDLE_SYSCLK_ON |-> st.gates.sysclk_on && st.gates.wdt_on && !st.gates.cpu_run;
  endproperty
  a_idle_on: assert property (p_idle_on) else $error("idle_sysclk_on gates wrong");

  property p_div_two;
    st.gates.sysclk_on && !st.high_clock_select && st.div_sel == 3'h7 && st.tick
      && $stable(st.div_sel) |=> !st.tick;
  endproperty
  a_div_two: assert property (p_div_two) else $error("divide by two ticks back to back");

  property p_hready_low;
    !st.gates.high_osc_on |=> !st.high_osc_ready;
  endproperty
  a_hready_low: assert property (p_hready_low) else $error("high ready while stopped");

  property p_lready_deep;
    st.mode == OMCG_DEEP_SLEEP ##1 st.mode == OMCG_DEEP_SLEEP |-> !st.low_osc_ready;
  endproperty
  a_lready_deep: assert property (p_lready_deep) else $error("low ready in deep sleep");

  property p_ready_wr;
    psel && penable && pready && pwrite && paddr == OMCG_SMC_OFS && st.gates.high_osc_on
      && st.high_osc_ready |=> st.high_osc_ready;
  endproperty
  a_ready_wr: assert property (p_ready_wr) else $error("write changed ready flag");

  c_deep:    cover property (st.mode == OMCG_DEEP_SLEEP ##1 wake_req);
  c_idle_on: cover property (st.mode == OMCG_IDLE_SYSCLK_ON);
  c_hready:  cover property ($rose(st.high_osc_ready));
endmodule
`default_nettype wire

/* File: dv/omcg_osc_model.sv */
// oscillator model: high and low speed oscillators seen by the mode controller
// assumes gates come straight from the controller; ticks run free of pclk phase
`timescale 1ns/1ps
`default_nettype none
module omcg_osc_model
  import omcg_pkg::*;
#(
  parameter int HIGH_HALF_NS = 40,
  parameter int LOW_HALF_NS  = 160
)
(
  input  wire omcg_pkg::omcg_gates_s gates,
  output logic                       high_osc_tick,
  output logic                       low_osc_tick
);
  // a stopped oscillator rests low, so a switched-off source yields no edges
  initial
  begin
    high_osc_tick = 1'b0;
    #3;
    forever
    begin
      #(HIGH_HALF_NS);
      high_osc_tick = (gates.high_osc_on === 1'b1) ? ~high_osc_tick : 1'b0;
    end
  end

  initial
  begin
    low_osc_tick = 1'b0;
    #7;
    forever
    begin
      #(LOW_HALF_NS);
      low_osc_tick = (gates.low_osc_on === 1'b1) ? ~low_osc_tick : 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: dv/operating_mode_clock_gating_bench.sv */
// self-checking bench for the mode controller: apb master, core pulses, monitor
// assumes the oscillator model drives 8 and 32 pclk tick periods
`timescale 1ns/1ps
`default_nettype none
module operating_mode_clock_gating_bench;
  import omcg_pkg::*;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} omcg_rd_s;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         halt_req, wake_req, high_osc_tick, low_osc_tick, sysclk_tick;
  logic         win, win_q, req_q;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, r, e;
  omcg_gates_s  gates;
  omcg_rd_s     rd_q[$];
  logic [15:0]  gate_q[$];
  int           tick_q[$];
  int           miscompares, check_count, tick_cnt;
  // smc, cfg, expected gates, mask of the gates that the mode fixes
  // cfg field order follows the package struct: bit5 keep, 4 lvd, 3 wdt_en, 2 wdt_src_sub
  logic [31:0]  tbl [6] = '{32'h0100_00D7, 32'h0110_06D7, 32'h010C_06D7,
                            32'h0300_05D7, 32'h030C_07D7, 32'h0320_47C7};

  omcg_ctrl i_omcg_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_req(halt_req), .wake_req(wake_req),
    .high_osc_tick(high_osc_tick), .low_osc_tick(low_osc_tick), .gates(gates),
    .sysclk_tick(sysclk_tick));
  omcg_osc_model i_omcg_osc_model (.gates(gates), .high_osc_tick(high_osc_tick),
    .low_osc_tick(low_osc_tick));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic test_done;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fail(input string msg);
    miscompares++;
    $display("ERROR %0t %s", $time, msg);
  endtask

  task automatic cmp_rd(input omcg_rd_s x);
    check_count++;
    if (((prdata & x.mask) !== (x.data & x.mask)) || (pslverr !== x.err))
      fail($sformatf("read %h err %b exp %h", prdata, pslverr, x.data));
  endtask

  task automatic cmp_gates(input logic [15:0] x);
    check_count++;
    if ((gates & x[7:0]) !== x[15:8])
      fail($sformatf("gates %h exp %h", gates, x[15:8]));
  endtask

  task automatic cmp_ticks(input int x);
    check_count++;
    if (tick_cnt < x - 1 || tick_cnt > x + 1)
      fail($sformatf("ticks %0d exp %0d", tick_cnt, x));
  endtask

  // monitor: every result takes the oldest note of its kind
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      if (rd_q.size() == 0)
        fail("unexpected read");
      else
        cmp_rd(rd_q.pop_front());
    end
    if (req_q && gate_q.size() != 0)
      cmp_gates(gate_q.pop_front());
    if (win === 1'b1 && sysclk_tick === 1'b1)
      tick_cnt++;
    if (win_q && win !== 1'b1 && tick_q.size() != 0)
    begin
      cmp_ticks(tick_q.pop_front());
      tick_cnt = 0;
    end
    req_q = (halt_req === 1'b1) || (wake_req === 1'b1);
    win_q = (win === 1'b1);
  end

  // reads carry the expected word in d; ends one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic err);
    int n;
    if (!wr)
      rd_q.push_back('{d, m, err});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fail("no pready");
      test_done;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input logic h, input logic [7:0] x, input logic [7:0] m);
    gate_q.push_back({x & m, m});
    if (h)
      halt_req <= 1'b1;
    else
      wake_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic tick_win(input logic [7:0] smc, input int x);
    apb(1'b1, OMCG_SMC_OFS, {24'h0, smc}, 32'h0, 1'b0);
    // leaves room for an oscillator restart and its ready count
    repeat (300) @(posedge pclk);
    tick_q.push_back(x);
    win <= 1'b1;
    repeat (1024) @(posedge pclk);
    win <= 1'b0;
    @(posedge pclk);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, halt_req, wake_req, win, win_q, req_q} = 9'h000;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    check_count = 0;
    tick_cnt = 0;
    void'($urandom(46));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    r = $urandom;
    apb(1'b0, OMCG_SMC_OFS, 32'h03, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, OMCG_SMC_OFS, {r[31:8], 3'h0, r[4], 4'hF}, 32'h0, 1'b0);
    apb(1'b0, OMCG_SMC_OFS, {27'h0, r[4], 4'h3}, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, OMCG_STAT_OFS, 32'hDF01, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, OMCG_STAT_OFS, r, 32'h0, 1'b0);
    apb(1'b0, 8'h0C, 32'h0, 32'hFFFF_FFFF, 1'b1);
    $display("test registers done");
    foreach (tbl[i])
    begin
      e = tbl[i];
      apb(1'b1, OMCG_CFG_OFS, {24'h0, e[23:16]}, 32'h0, 1'b0);
      apb(1'b1, OMCG_SMC_OFS, {24'h0, e[31:24]}, 32'h0, 1'b0);
      pulse(1'b1, e[15:8], e[7:0]);
      pulse(1'b1, e[15:8], e[7:0]);
      pulse(1'b0, 8'hDF, 8'hFF);
    end
    $display("test halted modes done");
    // halt must reach a sleep mode here, so idle_on_halt goes low
    apb(1'b1, OMCG_SMC_OFS, 32'h01, 32'h0, 1'b0);
    for (int c = 0; c < 2; c++)
    begin
      apb(1'b1, OMCG_CFG_OFS, {30'h0, c[0], c[0]}, 32'h0, 1'b0);
      pulse(1'b1, 8'h00, 8'hD7);
      apb(1'b0, OMCG_SMC_OFS, 32'h0, 32'h0C, 1'b0);
      pulse(1'b0, 8'hDF, 8'hFF);
      apb(1'b0, OMCG_SMC_OFS, 32'h0, 32'h0C, 1'b0);
      repeat (c ? 7000 : 400) @(posedge pclk);
      apb(1'b0, OMCG_SMC_OFS, c ? 32'h0 : 32'h0C, 32'h0C, 1'b0);
      if (c)
      begin
        repeat (2000) @(posedge pclk);
        apb(1'b0, OMCG_SMC_OFS, 32'h04, 32'h0C, 1'b0);
        // low crystal needs 1024 edges of a 32-cycle period
        repeat (24500) @(posedge pclk);
        apb(1'b0, OMCG_SMC_OFS, 32'h0C, 32'h0C, 1'b0);
      end
    end
    $display("test ready flags done");
    apb(1'b1, OMCG_CFG_OFS, 32'h0, 32'h0, 1'b0);
    tick_win(8'h00, 32);
    apb(1'b0, OMCG_STAT_OFS, 32'hEF02, 32'hFFFF, 1'b0);
    tick_win(8'h20, 32);
    for (int k = 2; k < 8; k++)
      tick_win({k[2:0], 5'h00}, 128 >> (8 - k));
    tick_win(8'h01, 128);
    $display("test clock select done");
    test_done;
  end
endmodule
`default_nettype wire
